// ===== rtl/samrd_pkg.sv
package samrd_pkg;
    localparam int unsigned SAMRD_W = 24;
    localparam int unsigned SAMRD_CW = 5;
    localparam logic [SAMRD_CW-1:0] SAMRD_STEPS = 5'h18;
    localparam logic [SAMRD_CW-1:0] SAMRD_HALF = 5'h0c;
    localparam logic [SAMRD_W-1:0] SAMRD_ZERO = 24'h000000;
    localparam int unsigned SAMRD_SIGN = 23;

    typedef enum logic [2:0]
    {
        SAMRD_OP_NONE = 3'h0,
        SAMRD_OP_MUL = 3'h1,
        SAMRD_OP_DIV = 3'h2,
        SAMRD_OP_RSH = 3'h3,
        SAMRD_OP_LROT = 3'h4,
        SAMRD_OP_FIX = 3'h5,
        SAMRD_OP_LOAD = 3'h6
    } samrd_op_t;
endpackage

// ===== rtl/samrd_if.sv
`timescale 1ns/1ps
`default_nettype none
interface samrd_if
    import samrd_pkg::*;
();
    logic cmd_valid;
    samrd_op_t cmd_op;
    logic [SAMRD_CW-1:0] cmd_count;
    logic [SAMRD_W-1:0] ld_acc;
    logic [SAMRD_W-1:0] ld_mq;
    logic [SAMRD_W-1:0] ld_opr;
    logic busy;
    logic done;
    logic [SAMRD_W-1:0] acc;
    logic [SAMRD_W-1:0] mq;
    logic [SAMRD_W-1:0] opr;

    modport dev
    (
        input cmd_valid, cmd_op, cmd_count, ld_acc, ld_mq, ld_opr,
        output busy, done, acc, mq, opr
    );
    modport seq
    (
        output cmd_valid, cmd_op, cmd_count, ld_acc, ld_mq, ld_opr,
        input busy, done, acc, mq, opr
    );
endinterface
`default_nettype wire

// ===== rtl/samrd_oc_add.sv
`timescale 1ns/1ps
`default_nettype none
module samrd_oc_add
    import samrd_pkg::*;
(
    input wire logic [SAMRD_W-1:0] a,
    input wire logic [SAMRD_W-1:0] b,
    input wire logic sub,
    output logic [SAMRD_W-1:0] y
);
    logic [SAMRD_W-1:0] bb;
    logic [SAMRD_W:0] s;
    // Subtractive form with end-around borrow: an equal pair gives +0, never -0,
    // so a divide step whose partial dividend equals the divisor sets its bit
    always_comb
    begin
        bb = sub ? b : ~b;
        s = {1'b0, a} - {1'b0, bb};
        y = s[SAMRD_W-1:0] - {{(SAMRD_W-1){1'b0}}, s[SAMRD_W]};
    end
endmodule
`default_nettype wire

// ===== rtl/samrd_dev.sv
`timescale 1ns/1ps
`default_nettype none
module samrd_dev
    import samrd_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    samrd_if.dev bus
);
    typedef enum logic [1:0]
    {
        SAMRD_S_IDLE = 2'b00,
        SAMRD_S_SUB = 2'b01,
        SAMRD_S_REST = 2'b11,
        SAMRD_S_ROT = 2'b10
    } samrd_state_t;

    typedef struct packed
    {
        samrd_state_t st;
        logic [SAMRD_W-1:0] acc;
        logic [SAMRD_W-1:0] mq;
        logic [SAMRD_W-1:0] opr;
        logic [SAMRD_CW-1:0] cnt;
        logic busy;
        logic done;
    } samrd_dev_state_t;

    samrd_dev_state_t s_q, s_d;
    logic [SAMRD_W-1:0] add_a, add_y;
    logic add_sub;

    // One shared adder; every arithmetic step goes through it
    samrd_oc_add u_add
    (
        .a(add_a),
        .b(s_q.opr),
        .sub(add_sub),
        .y(add_y)
    );

    always_comb
    begin
        add_a = s_q.acc;
        add_sub = (s_q.st == SAMRD_S_SUB);
    end

    always_comb
    begin
        s_d = s_q;
        s_d.done = 1'b0;
        case (s_q.st)
            SAMRD_S_IDLE:
            begin
                if (bus.cmd_valid)
                begin
                    case (bus.cmd_op)
                        SAMRD_OP_MUL:
                        begin
                            if (s_q.mq[0])
                            begin
                                s_d.acc = {1'b0, add_y[SAMRD_W-1:1]};
                                s_d.mq = {add_y[0], s_q.mq[SAMRD_W-1:1]};
                            end
                            else
                            begin
                                s_d.acc = {1'b0, s_q.acc[SAMRD_W-1:1]};
                                s_d.mq = {s_q.acc[0], s_q.mq[SAMRD_W-1:1]};
                            end
                            s_d.done = 1'b1;
                        end
                        SAMRD_OP_RSH:
                        begin
                            // Extra right shift for early-stopped multiply
                            s_d.acc = {1'b0, s_q.acc[SAMRD_W-1:1]};
                            s_d.mq = {s_q.acc[0], s_q.mq[SAMRD_W-1:1]};
                            s_d.done = 1'b1;
                        end
                        SAMRD_OP_DIV:
                        begin
                            s_d.acc = {s_q.acc[SAMRD_W-2:0], s_q.mq[SAMRD_W-1]};
                            s_d.mq = {s_q.mq[SAMRD_W-2:0], 1'b0};
                            s_d.st = SAMRD_S_SUB;
                            s_d.busy = 1'b1;
                        end
                        SAMRD_OP_LROT:
                        begin
                            if (bus.cmd_count == SAMRD_CW'(0))
                            begin
                                s_d.done = 1'b1;
                            end
                            else
                            begin
                                s_d.cnt = bus.cmd_count;
                                s_d.st = SAMRD_S_ROT;
                                s_d.busy = 1'b1;
                            end
                        end
                        SAMRD_OP_FIX:
                        begin
                            if (s_q.acc[SAMRD_SIGN])
                            begin
                                s_d.acc = add_y;
                            end
                            s_d.done = 1'b1;
                        end
                        SAMRD_OP_LOAD:
                        begin
                            s_d.acc = bus.ld_acc;
                            s_d.mq = bus.ld_mq;
                            s_d.opr = bus.ld_opr;
                            s_d.done = 1'b1;
                        end
                        default:
                        begin
                            s_d.done = 1'b1;
                        end
                    endcase
                end
            end
            SAMRD_S_SUB:
            begin
                s_d.acc = add_y;
                if (add_y[SAMRD_SIGN])
                begin
                    s_d.st = SAMRD_S_REST;
                end
                else
                begin
                    s_d.mq[0] = 1'b1;
                    s_d.st = SAMRD_S_IDLE;
                    s_d.busy = 1'b0;
                    s_d.done = 1'b1;
                end
            end
            SAMRD_S_REST:
            begin
                s_d.acc = add_y;
                s_d.st = SAMRD_S_IDLE;
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end
            SAMRD_S_ROT:
            begin
                // One place per cycle keeps the shifter small
                s_d.acc = {s_q.acc[SAMRD_W-2:0], s_q.mq[SAMRD_W-1]};
                s_d.mq = {s_q.mq[SAMRD_W-2:0], s_q.acc[SAMRD_W-1]};
                s_d.cnt = s_q.cnt - SAMRD_CW'(1);
                if (s_q.cnt == SAMRD_CW'(1))
                begin
                    s_d.st = SAMRD_S_IDLE;
                    s_d.busy = 1'b0;
                    s_d.done = 1'b1;
                end
            end
            default:
            begin
                s_d.st = SAMRD_S_IDLE;
                s_d.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_q <= '{st: SAMRD_S_IDLE, acc: SAMRD_ZERO, mq: SAMRD_ZERO, opr: SAMRD_ZERO,
                     cnt: '0, busy: 1'b0, done: 1'b0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign bus.busy = s_q.busy;
    assign bus.done = s_q.done;
    assign bus.acc = s_q.acc;
    assign bus.mq = s_q.mq;
    assign bus.opr = s_q.opr;
endmodule
`default_nettype wire

// ===== rtl/samrd_seq.sv
`timescale 1ns/1ps
`default_nettype none
module samrd_seq
    import samrd_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic is_div,
    input wire logic [SAMRD_W-1:0] a_in,
    input wire logic [SAMRD_W-1:0] b_in,
    output logic ready,
    output logic fin,
    output logic [SAMRD_W-1:0] hi,
    output logic [SAMRD_W-1:0] lo,
    samrd_if.seq bus
);
    typedef enum logic [2:0]
    {
        SAMRD_Q_IDLE = 3'b000,
        SAMRD_Q_LOAD = 3'b001,
        SAMRD_Q_STEP = 3'b011,
        SAMRD_Q_FIX = 3'b010,
        SAMRD_Q_WAIT = 3'b110,
        SAMRD_Q_END = 3'b111
    } samrd_qstate_t;

    typedef struct packed
    {
        samrd_qstate_t st;
        logic div;
        logic [SAMRD_W-1:0] a;
        logic [SAMRD_W-1:0] b;
        logic [SAMRD_CW-1:0] n;
        logic vld;
        samrd_op_t op;
        logic ready;
        logic fin;
        logic [SAMRD_W-1:0] hi;
        logic [SAMRD_W-1:0] lo;
    } samrd_seq_state_t;

    samrd_seq_state_t s_q, s_d;

    // Operands are taken as magnitudes; signs are the caller's job
    always_comb
    begin
        s_d = s_q;
        s_d.vld = 1'b0;
        s_d.fin = 1'b0;
        case (s_q.st)
            SAMRD_Q_IDLE:
            begin
                if (start)
                begin
                    s_d.div = is_div;
                    s_d.a = {1'b0, a_in[SAMRD_W-2:0]};
                    s_d.b = {1'b0, b_in[SAMRD_W-2:0]};
                    s_d.ready = 1'b0;
                    s_d.vld = 1'b1;
                    s_d.op = SAMRD_OP_LOAD;
                    s_d.st = SAMRD_Q_LOAD;
                end
            end
            SAMRD_Q_LOAD:
            begin
                if (bus.done)
                begin
                    s_d.n = '0;
                    s_d.vld = 1'b1;
                    s_d.op = s_q.div ? SAMRD_OP_DIV : SAMRD_OP_MUL;
                    s_d.st = SAMRD_Q_STEP;
                end
            end
            SAMRD_Q_STEP:
            begin
                if (bus.done)
                begin
                    s_d.n = s_q.n + SAMRD_CW'(1);
                    if (s_q.n + SAMRD_CW'(1) == SAMRD_STEPS)
                    begin
                        s_d.vld = 1'b1;
                        s_d.op = s_q.div ? SAMRD_OP_FIX : SAMRD_OP_NONE;
                        s_d.st = SAMRD_Q_WAIT;
                    end
                    else
                    begin
                        s_d.vld = 1'b1;
                        // Multiplier used up: plain shifts finish without adding
                        if (!s_q.div && (s_q.b >> s_d.n) == SAMRD_ZERO)
                        begin
                            s_d.op = SAMRD_OP_RSH;
                        end
                    end
                end
            end
            SAMRD_Q_WAIT:
            begin
                if (bus.done)
                begin
                    s_d.st = SAMRD_Q_END;
                end
            end
            SAMRD_Q_END:
            begin
                s_d.hi = bus.acc;
                s_d.lo = bus.mq;
                s_d.fin = 1'b1;
                s_d.ready = 1'b1;
                s_d.st = SAMRD_Q_IDLE;
            end
            default:
            begin
                s_d.st = SAMRD_Q_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_q <= '{st: SAMRD_Q_IDLE, div: 1'b0, a: SAMRD_ZERO, b: SAMRD_ZERO, n: '0,
                     vld: 1'b0, op: SAMRD_OP_NONE, ready: 1'b1, fin: 1'b0,
                     hi: SAMRD_ZERO, lo: SAMRD_ZERO};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Early stop is finished by right shifts only; the rotate path stays unused here
    assign bus.cmd_valid = s_q.vld;
    assign bus.cmd_op = s_q.op;
    assign bus.cmd_count = SAMRD_HALF;
    assign bus.ld_acc = SAMRD_ZERO;
    assign bus.ld_mq = s_q.div ? s_q.a : s_q.b;
    assign bus.ld_opr = s_q.div ? s_q.b : s_q.a;
    assign ready = s_q.ready;
    assign fin = s_q.fin;
    assign hi = s_q.hi;
    assign lo = s_q.lo;
endmodule
`default_nettype wire

// ===== tb/samrd_props.sv
`timescale 1ns/1ps
`default_nettype none
module samrd_props
    import samrd_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire samrd_op_t cmd_op,
    input wire logic [SAMRD_W-1:0] ld_acc,
    input wire logic [SAMRD_W-1:0] ld_mq,
    input wire logic [SAMRD_W-1:0] ld_opr,
    input wire logic busy,
    input wire logic done,
    input wire logic [SAMRD_W-1:0] acc,
    input wire logic [SAMRD_W-1:0] mq,
    input wire logic [SAMRD_W-1:0] opr
);
    logic [SAMRD_W-1:0] acc_p;
    logic [SAMRD_W-1:0] mq_p;
    logic [SAMRD_W-1:0] opr_p;
    logic [SAMRD_W-1:0] ms;
    logic [SAMRD_W-1:0] fx;
    logic div1_q;
    logic take;

    // Reference adder kept apart from the design's so a shared slip cannot hide
    function automatic logic [SAMRD_W-1:0] oc_add(input logic [SAMRD_W-1:0] a,
        input logic [SAMRD_W-1:0] b);
        logic [SAMRD_W:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[SAMRD_W-1:0] + {23'h000000, s[SAMRD_W]};
    endfunction

    assign take = cmd_valid && !busy;
    assign ms = mq_p[0] ? oc_add(acc_p, opr_p) : acc_p;
    assign fx = acc_p[SAMRD_SIGN] ? oc_add(acc_p, opr_p) : acc_p;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            acc_p <= SAMRD_ZERO;
            mq_p <= SAMRD_ZERO;
            opr_p <= SAMRD_ZERO;
            div1_q <= 1'b0;
        end
        else
        begin
            acc_p <= acc;
            mq_p <= mq;
            opr_p <= opr;
            div1_q <= take && cmd_op == SAMRD_OP_DIV;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_mul_step: assert property (take && cmd_op == SAMRD_OP_MUL |=> done
        && acc == {1'b0, ms[23:1]} && mq == {ms[0], mq_p[23:1]})
        else $error("multiply step result wrong");
    a_div_shift: assert property (take && cmd_op == SAMRD_OP_DIV |=> busy
        && {acc, mq} == {acc_p[22:0], mq_p, 1'b0})
        else $error("divide shift wrong");
    a_div_set_bit: assert property (div1_q && acc >= opr |=> done && !busy
        && mq == {mq_p[23:1], 1'b1} && acc == acc_p - opr_p)
        else $error("divide positive step wrong");
    a_div_restore: assert property (div1_q && acc < opr |=> !done
        && acc[SAMRD_SIGN] && mq == mq_p ##1 done && !busy && acc == $past(acc, 2))
        else $error("divide restore wrong");
    a_fix_remainder: assert property (take && cmd_op == SAMRD_OP_FIX |=> done
        && acc == fx)
        else $error("remainder fix wrong");
    a_load_regs: assert property (take && cmd_op == SAMRD_OP_LOAD |=> done
        && acc == $past(ld_acc) && mq == $past(ld_mq) && opr == $past(ld_opr))
        else $error("load wrong");
    a_done_bounded: assert property (take |-> ##[1:33] done)
        else $error("no completion");
    a_done_cause: assert property (done |-> $past(take) || $past(busy))
        else $error("completion without command");
    a_idle_hold: assert property (!busy && !cmd_valid |=> !done
        && $stable(acc) && $stable(mq))
        else $error("registers moved while idle");

    c_mul_add: cover property (take && cmd_op == SAMRD_OP_MUL && mq[0]);
    c_div_restore: cover property (div1_q && acc < opr);
    c_div_set: cover property (div1_q && acc >= opr);
    c_fix: cover property (take && cmd_op == SAMRD_OP_FIX);
    c_rsh: cover property (take && cmd_op == SAMRD_OP_RSH);
endmodule
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import samrd_pkg::*;

    logic clk;
    logic rst;
    logic start;
    logic is_div;
    logic [SAMRD_W-1:0] a_in;
    logic [SAMRD_W-1:0] b_in;
    logic ready;
    logic fin;
    logic [SAMRD_W-1:0] hi;
    logic [SAMRD_W-1:0] lo;
    int n_fail = 0;
    int checks = 0;
    int cycles = 0;

    samrd_if link();

    samrd_dev u_samrd_dev (.clk(clk), .rst(rst), .bus(link.dev));

    samrd_seq u_samrd_seq (.clk(clk), .rst(rst), .start(start), .is_div(is_div),
        .a_in(a_in), .b_in(b_in), .ready(ready), .fin(fin), .hi(hi), .lo(lo),
        .bus(link.seq));

    samrd_props u_samrd_props (.clk(clk), .rst(rst), .cmd_valid(link.cmd_valid),
        .cmd_op(link.cmd_op), .ld_acc(link.ld_acc), .ld_mq(link.ld_mq),
        .ld_opr(link.ld_opr), .busy(link.busy), .done(link.done), .acc(link.acc),
        .mq(link.mq), .opr(link.opr));

    always #2.5 clk = ~clk;

    task automatic wrap_up();
        if (n_fail == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic cmp(input logic [SAMRD_W-1:0] got, input logic [SAMRD_W-1:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t result %h expected %h", $time, got, exp);
        end
    endtask

    // Operands stay below the sign bit: the hardware only handles positive values
    task automatic run(input logic d, input logic [SAMRD_W-1:0] a,
        input logic [SAMRD_W-1:0] b);
        logic [47:0] p;
        int n;
        p = d ? {24'(a % b), 24'(a / b)} : 48'(a) * 48'(b);
        n = 0;
        while (ready !== 1'b1 && n < 200)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        @(posedge clk);
        start <= 1'b1;
        is_div <= d;
        a_in <= a;
        b_in <= b;
        @(posedge clk);
        start <= 1'b0;
        n = 0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end
        while (fin !== 1'b1 && n < 200);
        if (fin !== 1'b1)
        begin
            n_fail++;
            $display("[ERR] %0t no finish pulse", $time);
        end
        cmp(hi, p[47:24]);
        cmp(lo, p[23:0]);
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_fail++;
            wrap_up();
        end
    end

    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        start = 1'b0;
        is_div = 1'b0;
        a_in = 24'h000000;
        b_in = 24'h000000;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        run(1'b0, 24'h000013, 24'h00001d);
        run(1'b0, 24'h7fffff, 24'h7fffff);
        run(1'b0, 24'h000000, 24'h123456);
        run(1'b0, 24'h400001, 24'h000002);
        run(1'b1, 24'h000028, 24'h000003);
        run(1'b1, 24'h000006, 24'h000003);
        run(1'b1, 24'h000005, 24'h000007);
        run(1'b1, 24'h7fffff, 24'h000001);
        run(1'b1, 24'h7fffff, 24'h7fffff);
        run(1'b1, 24'h123456, 24'h000100);
        wrap_up();
    end
endmodule
`default_nettype wire
